// file: shared/ubrg_defines.vh
// Summary of operation
// - One divisor timer, 8 or 16 bits wide, paces async and sync serial.
// - Reset leaves 8-bit mode; wide_divisor_select bit chooses 16-bit mode.
// - Timer runs freely, period set by the low register, or the high and low pair in 16-bit mode.
// - Async multiplier depends on high_rate_select and wide_divisor_select.
// - Sync mode ignores high_rate_select; multiplier is 4 whatever the width select.
// - Writing either divisor register clears the timer at once.
// - Rate is Fosc/(k(n+1)), k 64, 16 or 4 by mode.
// - Low register holds divisor bits 7..0, high register bits 15..8.
// - high_rate_select is transmit control bit 2, sync select bit 4.
// - Baud control bits 5 and 2 read zero and ignore writes.
`ifndef UBRG_DEFINES_VH
`define UBRG_DEFINES_VH

`define UBRG_OFF_BAUD_CONTROL 3'h0
`define UBRG_OFF_RX_CONTROL 3'h1
`define UBRG_OFF_DIV_LOW 3'h2
`define UBRG_OFF_DIV_HIGH 3'h3
`define UBRG_OFF_TX_CONTROL 3'h4
`define UBRG_OFF_LAST 3'h4

`define UBRG_BC_OVF_BIT 7
`define UBRG_BC_IDLE_BIT 6
`define UBRG_BC_POL_BIT 4
`define UBRG_BC_WIDE_BIT 3
`define UBRG_BC_WUE_BIT 1
`define UBRG_BC_AUTO_RATE_ENABLE_BIT 0
`define UBRG_TX_HIGH_BIT 2
`define UBRG_TX_SYNC_BIT 4
`define UBRG_TX_EMPTY_BIT 1

`define UBRG_RST_BYTE 8'h00
`define UBRG_RST_WORD 32'h00000000

`define UBRG_SEL_K64 2'h0
`define UBRG_SEL_K16 2'h1
`define UBRG_SEL_K4 2'h2
`define UBRG_K64_MAX 6'h3F
`define UBRG_K16_MAX 6'h0F
`define UBRG_K4_MAX 6'h03
`define UBRG_ABD_EDGES 3'h5
`define UBRG_ABD_RAW_MAX 24'hFFFFFF

`endif

// file: design/ubrg_timer.v
`timescale 1ns/1ps
`default_nettype none
`include "ubrg_defines.vh"
module ubrg_timer (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  input wire ce,
  // Control
  input wire clear,
  input wire wide,
  input wire [1:0] rate_sel,
  input wire [15:0] divisor,
  // Rate output
  output reg tick_reg
);
  reg [5:0] prescale_reg;
  reg [15:0] count_reg;
  reg [5:0] prescale_max;
  reg count_hit;

  always @* begin
    case (rate_sel)
      `UBRG_SEL_K64: prescale_max = `UBRG_K64_MAX;
      `UBRG_SEL_K16: prescale_max = `UBRG_K16_MAX;
      default: prescale_max = `UBRG_K4_MAX;
    endcase
  end

  // Narrow mode compares low byte only, so stale high bits do no harm
  always @* begin
    if (wide) begin
      count_hit = (count_reg == divisor);
    end else begin
      count_hit = (count_reg[7:0] == divisor[7:0]);
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prescale_reg <= 6'h00;
      count_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end else if (ce) begin
      if (clear) begin
        prescale_reg <= 6'h00;
        count_reg <= 16'h0000;
        tick_reg <= 1'b0;
      end else begin
        tick_reg <= 1'b0;
        if (prescale_reg == prescale_max) begin
          prescale_reg <= 6'h00;
          if (count_hit) begin
            count_reg <= 16'h0000;
            tick_reg <= 1'b1;
          end else begin
            count_reg <= count_reg + 16'h0001;
          end
        end else begin
          prescale_reg <= prescale_reg + 6'h01;
        end
      end
    end
  end
endmodule // ubrg_timer
`default_nettype wire

// file: design/ubrg_top.v
`timescale 1ns/1ps
`default_nettype none
`include "ubrg_defines.vh"
module ubrg_top (
  // Clock, reset, enable
  input wire hclk,
  input wire hresetn,
  input wire ce,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Serial logic side
  input wire rx_pin,
  input wire tx_data_in,
  input wire receiver_idle_flag,
  input wire transmit_shift_empty,
  input wire receive_interrupt_flag_clear,
  output wire rate_tick,
  output reg tx_data_out,
  output reg sample_on_rising,
  output reg receive_interrupt_flag,
  output reg [7:0] receive_status_control_reg,
  output reg [7:0] transmit_status_control_reg
);
  localparam ABD_IDLE = 2'h0;
  localparam ABD_WAIT = 2'h1;
  localparam ABD_MEAS = 2'h2;

  // Baud control fields and divisor registers
  reg pol_reg;
  reg wide_reg;
  reg wue_reg;
  reg auto_rate_enable_reg;
  reg ovf_reg;
  reg [7:0] div_low_reg;
  reg [7:0] div_high_reg;

  // Bus pipeline
  reg wr_pend_reg;
  reg rd_pend_reg;
  reg hit_reg;
  reg [2:0] idx_reg;

  // Receive pin synchroniser and edge detect
  reg rx_meta_reg;
  reg rx_sync_reg;
  reg rx_prev_reg;

  // Auto-rate measurement
  reg [1:0] abd_state_reg;
  reg [23:0] abd_raw_reg;
  reg [2:0] abd_edges_reg;

  wire addr_phase;
  wire addr_hit;
  wire rx_fall;
  wire rx_rise;
  wire sync_mode;
  wire [1:0] rate_sel;
  wire wr_bc;
  wire wr_div;
  wire wr_cfg;
  wire abd_done;
  wire [23:0] abd_quot;
  wire [23:0] abd_div;
  wire abd_fits;
  reg timer_clear;
  reg [7:0] rd_byte;

  function [1:0] ubrg_rate_sel;
    input sync;
    input wide;
    input high;
    begin
      if (sync) begin
        ubrg_rate_sel = `UBRG_SEL_K4;
      end else if (!wide && !high) begin
        ubrg_rate_sel = `UBRG_SEL_K64;
      end else if (wide && high) begin
        ubrg_rate_sel = `UBRG_SEL_K4;
      end else begin
        ubrg_rate_sel = `UBRG_SEL_K16;
      end
    end
  endfunction

  // Eight bit times of a 0x55 character, divided by 8k
  function [23:0] ubrg_abd_scale;
    input [23:0] raw;
    input [1:0] sel;
    begin
      case (sel)
        `UBRG_SEL_K64: ubrg_abd_scale = {9'h000, raw[23:9]};
        `UBRG_SEL_K16: ubrg_abd_scale = {7'h00, raw[23:7]};
        default: ubrg_abd_scale = {5'h00, raw[23:5]};
      endcase
    end
  endfunction

  assign addr_phase = hsel && htrans[1] && hready;
  assign addr_hit = (haddr[31:5] == 27'h0000000) &&
                    (haddr[1:0] == 2'h0) &&
                    (haddr[4:2] <= `UBRG_OFF_LAST);
  assign sync_mode = transmit_status_control_reg[`UBRG_TX_SYNC_BIT];
  assign rate_sel = ubrg_rate_sel(sync_mode, wide_reg,
    transmit_status_control_reg[`UBRG_TX_HIGH_BIT]);
  assign rx_fall = rx_prev_reg && !rx_sync_reg;
  assign rx_rise = !rx_prev_reg && rx_sync_reg;
  assign wr_bc = wr_pend_reg && hit_reg &&
                 (idx_reg == `UBRG_OFF_BAUD_CONTROL);
  assign wr_div = wr_pend_reg && hit_reg &&
                  ((idx_reg == `UBRG_OFF_DIV_LOW) ||
                   (idx_reg == `UBRG_OFF_DIV_HIGH));
  assign wr_cfg = wr_pend_reg && hit_reg &&
                  (idx_reg == `UBRG_OFF_TX_CONTROL);
  assign abd_done = (abd_state_reg == ABD_MEAS) && rx_rise &&
                    (abd_edges_reg == `UBRG_ABD_EDGES - 3'h1);
  assign abd_quot = ubrg_abd_scale(abd_raw_reg, rate_sel);
  assign abd_div = abd_quot - 24'h000001;
  assign abd_fits = (abd_quot != 24'h000000) &&
                    (wide_reg ? (abd_div[23:16] == 8'h00)
                              : (abd_div[23:8] == 16'h0000));

  // Mode changes also restart the count so a shorter period is not missed
  always @* begin
    timer_clear = wr_div || wr_bc || wr_cfg || abd_done;
  end

  ubrg_timer u_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .clear(timer_clear),
    .wide(wide_reg),
    .rate_sel(rate_sel),
    .divisor({div_high_reg, div_low_reg}),
    .tick_reg(rate_tick)
  );

  always @* begin
    rd_byte = 8'h00;
    case (idx_reg)
      `UBRG_OFF_BAUD_CONTROL: begin
        rd_byte[`UBRG_BC_OVF_BIT] = ovf_reg;
        rd_byte[`UBRG_BC_IDLE_BIT] = receiver_idle_flag;
        rd_byte[`UBRG_BC_POL_BIT] = pol_reg;
        rd_byte[`UBRG_BC_WIDE_BIT] = wide_reg;
        rd_byte[`UBRG_BC_WUE_BIT] = wue_reg;
        rd_byte[`UBRG_BC_AUTO_RATE_ENABLE_BIT] = auto_rate_enable_reg;
      end
      `UBRG_OFF_RX_CONTROL: rd_byte = receive_status_control_reg;
      `UBRG_OFF_DIV_LOW: rd_byte = div_low_reg;
      `UBRG_OFF_DIV_HIGH: rd_byte = div_high_reg;
      `UBRG_OFF_TX_CONTROL: begin
        rd_byte = transmit_status_control_reg;
        rd_byte[`UBRG_TX_EMPTY_BIT] = transmit_shift_empty;
      end
      default: rd_byte = 8'h00;
    endcase
    if (!hit_reg) begin
      rd_byte = 8'h00;
    end
  end

  // Bus: writes take no wait state, reads take one
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `UBRG_RST_WORD;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      hit_reg <= 1'b0;
      idx_reg <= 3'h0;
    end else if (ce) begin
      hresp <= 1'b0;
      wr_pend_reg <= 1'b0;
      if (rd_pend_reg) begin
        hrdata <= {24'h000000, rd_byte};
        hreadyout <= 1'b1;
        rd_pend_reg <= 1'b0;
      end else if (addr_phase) begin
        hit_reg <= addr_hit;
        idx_reg <= haddr[4:2];
        wr_pend_reg <= hwrite;
        rd_pend_reg <= !hwrite;
        hreadyout <= hwrite;
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end else if (ce) begin
      rx_meta_reg <= rx_pin;
      rx_sync_reg <= rx_meta_reg;
      rx_prev_reg <= rx_sync_reg;
    end
  end

  // Software registers; bus writes win over hardware clears, auto-rate results win over bus writes
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pol_reg <= 1'b0;
      wide_reg <= 1'b0;
      wue_reg <= 1'b0;
      auto_rate_enable_reg <= 1'b0;
      ovf_reg <= 1'b0;
      div_low_reg <= `UBRG_RST_BYTE;
      div_high_reg <= `UBRG_RST_BYTE;
      receive_status_control_reg <= `UBRG_RST_BYTE;
      transmit_status_control_reg <= `UBRG_RST_BYTE;
    end else if (ce) begin
      if (wr_bc) begin
        pol_reg <= hwdata[`UBRG_BC_POL_BIT];
        wide_reg <= hwdata[`UBRG_BC_WIDE_BIT];
        wue_reg <= hwdata[`UBRG_BC_WUE_BIT];
        auto_rate_enable_reg <= hwdata[`UBRG_BC_AUTO_RATE_ENABLE_BIT];
      end else begin
        if (wue_reg && !sync_mode && rx_fall) begin
          wue_reg <= 1'b0;
        end
        if (abd_done) begin
          auto_rate_enable_reg <= 1'b0;
        end
      end
      if (abd_done && !abd_fits) begin
        ovf_reg <= 1'b1;
      end else if (wr_bc && hwdata[`UBRG_BC_AUTO_RATE_ENABLE_BIT]) begin
        ovf_reg <= 1'b0;
      end
      if (abd_done && abd_fits) begin
        div_low_reg <= abd_div[7:0];
        if (wide_reg) begin
          div_high_reg <= abd_div[15:8];
        end
      end else if (wr_div && idx_reg == `UBRG_OFF_DIV_LOW) begin
        div_low_reg <= hwdata[7:0];
      end else if (wr_div) begin
        div_high_reg <= hwdata[7:0];
      end
      if (wr_pend_reg && hit_reg && idx_reg == `UBRG_OFF_RX_CONTROL) begin
        receive_status_control_reg <= hwdata[7:0];
      end
      if (wr_cfg) begin
        transmit_status_control_reg <= hwdata[7:0];
      end
    end
  end

  // Count from first to fifth rise of a 0x55 character: eight bit times
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      abd_state_reg <= ABD_IDLE;
      abd_raw_reg <= 24'h000000;
      abd_edges_reg <= 3'h0;
    end else if (ce) begin
      case (abd_state_reg)
        ABD_IDLE: begin
          if (auto_rate_enable_reg && !sync_mode) begin
            abd_state_reg <= ABD_WAIT;
          end
        end
        ABD_WAIT: begin
          if (!auto_rate_enable_reg || sync_mode) begin
            abd_state_reg <= ABD_IDLE;
          end else if (rx_fall) begin
            abd_state_reg <= ABD_MEAS;
            abd_raw_reg <= 24'h000000;
            abd_edges_reg <= 3'h0;
          end
        end
        ABD_MEAS: begin
          if (!auto_rate_enable_reg || sync_mode || abd_done) begin
            abd_state_reg <= ABD_IDLE;
          end else begin
            if ((abd_edges_reg != 3'h0 || rx_rise) &&
                abd_raw_reg != `UBRG_ABD_RAW_MAX) begin
              abd_raw_reg <= abd_raw_reg + 24'h000001;
            end
            if (rx_rise) begin
              abd_edges_reg <= abd_edges_reg + 3'h1;
            end
          end
        end
        default: abd_state_reg <= ABD_IDLE;
      endcase
    end
  end

  // Serial outputs and wake-up flag
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_data_out <= 1'b1;
      sample_on_rising <= 1'b0;
      receive_interrupt_flag <= 1'b0;
    end else if (ce) begin
      tx_data_out <= sync_mode ? tx_data_in
                               : (tx_data_in ^ pol_reg);
      sample_on_rising <= sync_mode && pol_reg;
      if (wue_reg && !sync_mode && rx_fall) begin
        receive_interrupt_flag <= 1'b1;
      end else if (receive_interrupt_flag_clear) begin
        receive_interrupt_flag <= 1'b0;
      end
    end
  end
endmodule // ubrg_top
`default_nettype wire

// file: tb/ubrg_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ubrg_checker (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // Serial side
  input wire logic rx_pin,
  input wire logic tx_data_in,
  input wire logic rate_tick,
  input wire logic tx_data_out,
  input wire logic sample_on_rising,
  input wire logic receive_interrupt_flag,
  input wire logic [7:0] transmit_status_control_reg
);
  logic ap_wr_reg, clr_d_reg, armed_reg, wide_reg, pol_reg;
  logic [2:0] ap_a_reg;
  logic [7:0] lo_reg, hi_reg;
  logic [23:0] cnt_reg, per;
  logic [6:0] k;
  logic sy, hr;
  assign sy = transmit_status_control_reg[4];
  assign hr = transmit_status_control_reg[2];
  assign k = sy ? 7'h04 : (!wide_reg & !hr) ? 7'h40 : (wide_reg & hr) ? 7'h04 : 7'h10;
  assign per = k * ({wide_reg ? hi_reg : 8'h00, lo_reg} + 17'h00001);
  // Shadow of the rate settings; every mapped write except rx control clears
  // Auto-rate reloads the divisor unseen, so arming waits for a later write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_reg <= 1'b0;
      ap_a_reg <= 3'h0;
      clr_d_reg <= 1'b0;
      armed_reg <= 1'b0;
      cnt_reg <= 24'h000000;
      lo_reg <= 8'h00;
      hi_reg <= 8'h00;
      wide_reg <= 1'b0;
      pol_reg <= 1'b0;
    end else if (ce) begin
      ap_wr_reg <= hsel & htrans[1] & hready & hwrite & (haddr[31:5] == 27'h0)
        & (haddr[1:0] == 2'h0) & (haddr[4:2] <= 3'h4) & (haddr[4:2] != 3'h1);
      ap_a_reg <= haddr[4:2];
      clr_d_reg <= ap_wr_reg;
      if (ap_wr_reg) begin
        cnt_reg <= 24'h000000;
        armed_reg <= !((ap_a_reg == 3'h0) & hwdata[0]);
      end else if (rate_tick & !clr_d_reg) cnt_reg <= 24'h000001;
      else cnt_reg <= cnt_reg + 24'h000001;
      if (ap_wr_reg & (ap_a_reg == 3'h2)) lo_reg <= hwdata[7:0];
      if (ap_wr_reg & (ap_a_reg == 3'h3)) hi_reg <= hwdata[7:0];
      if (ap_wr_reg & (ap_a_reg == 3'h0)) begin
        wide_reg <= hwdata[3];
        pol_reg <= hwdata[4];
      end
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_tick_period: assert property (armed_reg & !clr_d_reg |-> rate_tick == (cnt_reg == per))
    else $error("rate tick off its period");
  a_tick_pulse: assert property (rate_tick & ce |=> !rate_tick)
    else $error("rate tick longer than one cycle");
  a_clear_restart: assert property (ap_wr_reg & ce |=> ##1 !rate_tick [*3])
    else $error("tick too soon after clear");
  a_sync_edge: assert property (!clr_d_reg |-> sample_on_rising == (sy & pol_reg))
    else $error("sample edge select wrong");
  a_tx_polarity: assert property ($past(ce) |-> tx_data_out ==
    ($past(tx_data_in) ^ ($past(pol_reg) & !$past(sy))))
    else $error("transmit data polarity wrong");
  a_wake_flag: assert property ($rose(receive_interrupt_flag) |-> $past(rx_pin, 4) & !$past(rx_pin, 1))
    else $error("receive flag set without rx fall");
  a_read_wait: assert property (hsel & htrans[1] & hready & ce & !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  cover property (armed_reg & rate_tick);
  cover property ($rose(receive_interrupt_flag));
  cover property (sample_on_rising);
endmodule // ubrg_checker
bind ubrg_top ubrg_checker u_ubrg_checker (.hclk, .hresetn, .ce, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .rx_pin, .tx_data_in,
  .rate_tick, .tx_data_out, .sample_on_rising, .receive_interrupt_flag,
  .transmit_status_control_reg);
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic hclk, hresetn, ce, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic rx_pin, tx_data_in, receiver_idle_flag, transmit_shift_empty;
  logic receive_interrupt_flag_clear, rate_tick, tx_data_out, sample_on_rising;
  logic receive_interrupt_flag, sy, wd, hi, pol;
  logic [7:0] receive_status_control_reg, transmit_status_control_reg, lo, hv;
  logic [7:0] m [0:5];
  logic [9:0] fr;
  integer errors = 0, cmp_count = 0, seed = 32'he386, i, t, p;
  assign hready = hreadyout;
  ubrg_top u_ubrg_top (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .rx_pin,
    .tx_data_in, .receiver_idle_flag, .transmit_shift_empty, .receive_interrupt_flag_clear,
    .rate_tick, .tx_data_out, .sample_on_rising, .receive_interrupt_flag,
    .receive_status_control_reg, .transmit_status_control_reg);
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  task complete_run;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Bounded waits; a hung slave ends the run
  task bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    integer n;
    n = 0;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    rdv = hrdata;
    if (n >= 50) begin
      errors++;
      complete_run;
    end
  endtask
  function logic [7:0] ev(input integer a);
    if (a == 0) return m[0] | {1'b0, receiver_idle_flag, 6'h00};
    if (a == 4) return {m[4][7:2], transmit_shift_empty, m[4][0]};
    return m[a];
  endfunction
  task wr(input integer a, input logic [7:0] d);
    bus(32'(a * 4), 1'b1, {24'h000000, d});
    if (a == 0) m[0] = d & 8'h1B;
    else if (a < 5) m[a] = d;
  endtask
  task rd(input integer a);
    bus(32'(a * 4), 1'b0, 32'h00000000);
    chk(rdv, {24'h000000, ev(a)});
  endtask
  task wait_tick(output integer c);
    c = 0;
    do begin
      @(posedge hclk);
      #1;
      c++;
    end while (rate_tick !== 1'b1 && c < 20000);
    if (c >= 20000) begin
      errors++;
      complete_run;
    end
  endtask
  function integer per(input logic s, w, h, input logic [7:0] l, hh);
    integer k;
    k = s ? 4 : (!w && !h) ? 64 : (w && h) ? 4 : 16;
    return k * ((w ? hh * 256 : 0) + l + 1);
  endfunction
  initial begin
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    ce = 1'b1;
    rx_pin = 1'b1;
    tx_data_in = 1'b1;
    receiver_idle_flag = 1'b1;
    transmit_shift_empty = 1'b0;
    receive_interrupt_flag_clear = 1'b0;
    hresetn = 1'b0;
    for (i = 0; i < 6; i++) m[i] = 8'h00;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    for (i = 0; i < 6; i++) rd(i);
    wr(0, 8'hFC);
    rd(0);
    for (i = 1; i < 6; i++) begin
      transmit_shift_empty <= 1'($random(seed));
      receiver_idle_flag <= 1'($random(seed));
      wr(i, 8'($random(seed)));
      rd(i);
    end
    // Every width, rate and sync setting, each with its own divisor
    for (i = 0; i < 8; i++) begin
      {sy, wd, hi} = 3'(i);
      pol = 1'($random(seed));
      lo = 8'($random(seed)) & 8'h1F;
      hv = 8'($random(seed)) & 8'h01;
      wr(2, lo);
      wr(3, hv);
      wr(4, {3'h0, sy, 1'b0, hi, 2'h0});
      wr(0, {3'h0, pol, wd, 3'h0});
      p = per(sy, wd, hi, lo, hv);
      wait_tick(t);
      chk(t, p);
      wait_tick(t);
      chk(t, p);
      chk({transmit_status_control_reg[4], transmit_status_control_reg[2]}, {sy, hi});
      chk(sample_on_rising, sy & pol);
      @(posedge hclk);
      tx_data_in <= ~tx_data_in;
      @(posedge hclk);
      #1;
      chk(tx_data_out, tx_data_in ^ (pol & !sy));
    end
    wr(4, 8'h00);
    wr(0, 8'h02);
    rx_pin <= 1'b0;
    t = 0;
    do begin
      @(posedge hclk);
      #1;
      t++;
    end while (receive_interrupt_flag !== 1'b1 && t < 8);
    chk(receive_interrupt_flag, 1'b1);
    m[0] = 8'h00;
    rd(0);
    receive_interrupt_flag_clear <= 1'b1;
    @(posedge hclk);
    receive_interrupt_flag_clear <= 1'b0;
    rx_pin <= 1'b1;
    repeat (4) @(posedge hclk);
    rx_pin <= 1'b0;
    repeat (8) @(posedge hclk);
    #1;
    chk(receive_interrupt_flag, 1'b0);
    // Auto-rate: a 0x55 frame at 64(n+1) cycles a bit must load n
    rx_pin <= 1'b1;
    repeat (8) @(posedge hclk);
    lo = 8'($random(seed)) & 8'h07;
    wr(0, 8'h01);
    fr = {1'b1, 8'h55, 1'b0};
    for (i = 0; i < 10; i++) begin
      rx_pin <= fr[i];
      repeat (64 * (lo + 1)) @(posedge hclk);
    end
    m[0] = 8'h00;
    m[2] = lo;
    rd(0);
    rd(2);
    // Enable low for five cycles must stretch nothing but the wait
    wait_tick(t);
    ce <= 1'b0;
    repeat (5) @(posedge hclk);
    ce <= 1'b1;
    wait_tick(t);
    chk(t, per(1'b0, 1'b0, 1'b0, lo, 8'h00));
    complete_run;
  end
endmodule // tb
`default_nettype wire
